// File: pkg/ipc_pkg.sv
// shared constants and types of the interrupt priority command logic
package ipc_pkg;
	localparam int DATA_W = 8;
	localparam int CH_NUM = 8;
	localparam int LVL_W = 3;
	// register select values: command word at 0x0, mask word at 0x1
	localparam logic SEL_CMD = 1'b0;
	localparam logic SEL_MASK = 1'b1;
	// field positions of the command words
	localparam int CMD_OP_HI = 7;
	localparam int CMD_OP_LO = 5;
	localparam int CMD_KIND_HI = 4;
	localparam int CMD_KIND_LO = 3;
	localparam int CMD_LVL_HI = 2;
	localparam int CMD_LVL_LO = 0;
	localparam int SPEC_MASK_EN_BIT = 6;
	localparam int SPEC_MASK_BIT = 5;
	localparam int VEC_BASE_LO = 3;
	localparam logic [1:0] KIND_SECOND = 2'h0;
	localparam logic [1:0] KIND_THIRD = 2'h1;
	// rotate, level-select, end-of-service codes
	localparam logic [2:0] OP_ROT_AUTO_CLR = 3'h0;
	localparam logic [2:0] OP_NS_EOS = 3'h1;
	localparam logic [2:0] OP_NOP = 3'h2;
	localparam logic [2:0] OP_SP_EOS = 3'h3;
	localparam logic [2:0] OP_ROT_AUTO_SET = 3'h4;
	localparam logic [2:0] OP_ROT_NS_EOS = 3'h5;
	localparam logic [2:0] OP_SET_PRI = 3'h6;
	localparam logic [2:0] OP_ROT_SP_EOS = 3'h7;
	// reset values
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] ISR_RST = 8'h00;
	localparam logic [2:0] LOWEST_RST = 3'h7;
	localparam logic [2:0] DEFAULT_LVL = 3'h7;
	typedef enum logic [1:0] {ACK_IDLE, ACK_ONE, ACK_TWO, ACK_THREE}
		ipc_ack_state_t;
endpackage

// File: testbench/ipc_command_logic_tb.sv
// self-checking bench of the interrupt command logic
`timescale 1ns/10ps
module ipc_command_logic_tb;
	import ipc_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic SEL_N, REG_SELECT, WR_N, RD_N, INTERRUPT_ACKNOWLEDGE_STROBE_N, DATA_OE_N, INT_OUT;
	logic [7:0] DATA_IN, DATA_OUT, IN_SERVICE, v;
	logic [7:0] REQ = 8'h00;
	logic [7:0] VECTOR_BASE = 8'h48;
	logic INIT_DONE = 1'b0;
	logic AUTO_EOS = 1'b0;
	logic HOST_16BIT = 1'b1;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// mask, request, irq expected, level
	logic [31:0] rows [5] = '{32'h00810100, 32'h01810107, 32'hffff0000,
		32'h00300104, 32'h10300105};
	always #2 CLK_SYS = ~CLK_SYS;
	ipc_command_logic #(.CHANNELS(8)) ipc_command_logic_i (.CLK_SYS(CLK_SYS),
		.RST(RST), .SEL_N(SEL_N), .REG_SELECT(REG_SELECT), .WR_N(WR_N),
		.RD_N(RD_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
		.DATA_OE_N(DATA_OE_N), .INTERRUPT_ACKNOWLEDGE_STROBE_N(INTERRUPT_ACKNOWLEDGE_STROBE_N), .REQ(REQ),
		.INIT_DONE(INIT_DONE), .AUTO_EOS(AUTO_EOS), .HOST_16BIT(HOST_16BIT),
		.VECTOR_BASE(VECTOR_BASE), .INT_OUT(INT_OUT), .IN_SERVICE(IN_SERVICE));
	ipc_host_model ipc_host_model_i (.clk_sys(CLK_SYS), .sel_n(SEL_N),
		.reg_select(REG_SELECT), .wr_n(WR_N), .rd_n(RD_N), .interrupt_acknowledge_strobe_n(INTERRUPT_ACKNOWLEDGE_STROBE_N),
		.data_in(DATA_IN), .data_out(DATA_OUT), .data_oe_n(DATA_OE_N));
	task end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input string name, input logic [7:0] seen, input logic [7:0] e);
		samples_checked++;
		if (seen !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, e, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task wr(input logic s, input logic [7:0] d);
		ipc_host_model_i.wr(s, d);
	endtask
	task wr_is(input logic [7:0] d, input logic [7:0] e);
		wr(SEL_CMD, d);
		tick(1);
		check("in_service", IN_SERVICE, e);
	endtask
	task serve(input logic [7:0] r, input logic [2:0] lvl, input logic [7:0] e);
		REQ = r;
		tick(3);
		check("irq", {7'h0, INT_OUT}, 8'h01);
		ipc_host_model_i.ack(HOST_16BIT ? 2 : 3, v);
		check("vector", v, {VECTOR_BASE[7:3], lvl});
		REQ = 8'h00;
		tick(2);
		check("in_service", IN_SERVICE, e);
	endtask
	always @(posedge CLK_SYS)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	initial
	begin
		tick(16);
		RST = 1'b0;
		ipc_host_model_i.rd(v);
		check("mask", v, MASK_RST);
		check("oe_n", {7'h0, DATA_OE_N}, 8'h00);
		REQ = 8'h01;
		tick(4);
		check("irq", {7'h0, INT_OUT}, 8'h00);
		check("oe_n", {7'h0, DATA_OE_N}, 8'h01);
		REQ = 8'h00;
		INIT_DONE = 1'b1;
		$display("test done: reset");
		foreach (rows[i])
		begin
			wr(SEL_MASK, rows[i][31:24]);
			ipc_host_model_i.rd(v);
			check("mask", v, rows[i][31:24]);
			if (rows[i][8])
				serve(rows[i][23:16], rows[i][2:0], 8'h01 << rows[i][2:0]);
			else
			begin
				REQ = rows[i][23:16];
				tick(3);
				check("irq", {7'h0, INT_OUT}, 8'h00);
				REQ = 8'h00;
			end
			wr_is(8'h20, 8'h00);
		end
		$display("test done: rows");
		wr(SEL_MASK, 8'h00);
		serve(8'h20, 3'h5, 8'h20);
		REQ = 8'h80;
		tick(3);
		check("irq", {7'h0, INT_OUT}, 8'h00);
		serve(8'h08, 3'h3, 8'h28);
		wr_is(8'h30, 8'h28);
		wr_is(8'h40, 8'h28);
		wr_is(8'h20, 8'h20);
		wr_is(8'h65, 8'h00);
		$display("test done: nesting");
		wr(SEL_CMD, 8'hc3);
		serve(8'h11, 3'h4, 8'h10);
		wr_is(8'he4, 8'h00);
		serve(8'h21, 3'h5, 8'h20);
		wr_is(8'ha0, 8'h00);
		serve(8'h41, 3'h6, 8'h40);
		wr(SEL_CMD, 8'hc7);
		wr_is(8'h20, 8'h00);
		$display("test done: rotation");
		serve(8'h04, 3'h2, 8'h04);
		wr(SEL_CMD, 8'h68);
		wr(SEL_MASK, 8'h04);
		serve(8'h80, 3'h7, 8'h84);
		wr_is(8'h20, 8'h04);
		wr(SEL_CMD, 8'h28);
		serve(8'h08, 3'h3, 8'h0c);
		wr(SEL_CMD, 8'h48);
		wr(SEL_MASK, 8'h00);
		wr(SEL_CMD, 8'h62);
		wr_is(8'h63, 8'h00);
		$display("test done: special mask");
		AUTO_EOS = 1'b1;
		HOST_16BIT = 1'b0;
		serve(8'h02, 3'h1, 8'h00);
		wr(SEL_CMD, 8'h80);
		serve(8'h03, 3'h0, 8'h00);
		serve(8'h03, 3'h1, 8'h00);
		wr(SEL_CMD, 8'h00);
		serve(8'h06, 3'h2, 8'h00);
		serve(8'h06, 3'h2, 8'h00);
		$display("test done: automatic end");
		end_of_test();
	end
endmodule

// File: testbench/ipc_host_model.sv
// host processor model: command bus writes, mask reads, acknowledge pulses
`timescale 1ns/10ps
module ipc_host_model
(
	input wire logic clk_sys,
	output logic sel_n,
	output logic reg_select,
	output logic wr_n,
	output logic rd_n,
	output logic interrupt_acknowledge_strobe_n,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	logic [7:0] drv = 8'h00;
	logic [7:0] last = 8'h00;
	logic drv_en = 1'b0;
	initial
	begin
		sel_n = 1'b1;
		reg_select = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		interrupt_acknowledge_strobe_n = 1'b1;
	end
	// no pull on the bus, so a released bus toggles instead of holding
	assign data_in = !data_oe_n ? data_out : drv_en ? drv : ~last;
	always @(posedge clk_sys)
		last <= data_in;
	// no cascade, one end of service per handler
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		sel_n = 1'b0;
		reg_select = sel;
		wr_n = 1'b0;
		drv = d;
		drv_en = 1'b1;
		@(posedge clk_sys);
		#1;
		sel_n = 1'b1;
		wr_n = 1'b1;
		drv_en = 1'b0;
	endtask
	task automatic rd(output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		sel_n = 1'b0;
		reg_select = 1'b1;
		rd_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		d = data_out;
		sel_n = 1'b1;
		rd_n = 1'b1;
	endtask
	// low and high phases of two cycles each; only the last vector is kept
	task automatic ack(input int pulses, output logic [7:0] vec);
		repeat (pulses)
		begin
			@(posedge clk_sys);
			#1;
			interrupt_acknowledge_strobe_n = 1'b0;
			repeat (2) @(posedge clk_sys);
			#1;
			vec = data_out;
			interrupt_acknowledge_strobe_n = 1'b1;
			@(posedge clk_sys);
			#1;
		end
	endtask
endmodule

// File: verilog/ipc_command_logic.sv
// operation command and in-service logic of the interrupt controller
// Overview of operation
// [RULE_01] requests are acted on only once initialization has completed
// [RULE_02] mask register holds eight bits written by the first operation word
// [RULE_03] a mask bit of one disables only its own channel
// [RULE_04] codes 001 non-specific, 011 specific end of service, 010 no operation
// [RULE_05] codes 101, 100, 000, 111, 110 select the rotation commands
// [RULE_06] with level select set, the level field names the channel in binary
// [RULE_07] third word enters or leaves special mask only when its enable is set
// [RULE_08] fully nested priority is the default after initialization
// [RULE_09] after initialization channel 0 is highest and channel 7 lowest
// [RULE_10] acknowledge outputs the vector and sets the winner's in-service bit
// [RULE_11] in-service bit clears by command, or at final acknowledge if automatic
// [RULE_12] while in service, equal or lower priority requests are held off
// [RULE_13] rotation commands change the priority order
// [RULE_14] host issues an end of service command before leaving each handler
// [RULE_15] cascaded hosts send one end of service to master and one to slave
// [RULE_16] non-specific end of service clears the highest set in-service bit
// [RULE_17] specific end of service clears exactly the named in-service bit
// [RULE_18] in special mask, non-specific clear skips masked in-service bits
// [RULE_19] final acknowledge is the third pulse, or second in 16-bit host mode
// [RULE_20] in special mask mode every unmasked channel may raise a request; here a channel whose in-service bit is set is still held off
// [RULE_21] a read with register select high returns the mask register
// [RULE_22] select low with data bits 4 and 3 zero is the second operation word
// [RULE_23] the no-operation code changes no in-service, priority or rotation state
`timescale 1ns/10ps
module ipc_command_logic
#(
	parameter int CHANNELS = 8
)
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic SEL_N,
	input wire logic REG_SELECT,
	input wire logic WR_N,
	input wire logic RD_N,
	input wire logic [ipc_pkg::DATA_W-1:0] DATA_IN,
	output logic [ipc_pkg::DATA_W-1:0] DATA_OUT,
	output logic DATA_OE_N,
	input wire logic INTERRUPT_ACKNOWLEDGE_STROBE_N,
	input wire logic [CHANNELS-1:0] REQ,
	input wire logic INIT_DONE,
	input wire logic AUTO_EOS,
	input wire logic HOST_16BIT,
	input wire logic [ipc_pkg::DATA_W-1:0] VECTOR_BASE,
	output logic INT_OUT,
	output logic [CHANNELS-1:0] IN_SERVICE
);
	import ipc_pkg::*;

	if (CHANNELS != CH_NUM)
	begin : g_bad_channels
		$error("only eight channels are supported");
	end

	logic wr_n_d_r, interrupt_acknowledge_strobe_n_d_r;
	logic [7:0] mask_r, mask_nxt, isr_r, isr_nxt;
	logic [2:0] lowest_r, lowest_nxt, ack_lvl_r, ack_lvl_nxt;
	logic spec_mask_r, spec_mask_nxt, rot_r, rot_nxt;
	ipc_ack_state_t ack_st_r, ack_st_nxt;
	logic int_r, int_nxt, oe_n_r, oe_n_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic wr_go, cmd_go, third_go, mask_go, ack_fall, ack_rise, finish;
	logic ack_vec, rd_mask;
	logic [2:0] op, tgt;
	logic [7:0] req_live, req_view, isr_view;
	logic req_found, isr_found, req_wins;
	logic [2:0] req_lvl, isr_lvl;

	function automatic logic [2:0] rank(input logic [2:0] lvl,
		input logic [2:0] low);
		rank = lvl - low - 3'h1;
	endfunction

	// writes are taken on the first cycle of the strobe only
	assign wr_go = ~SEL_N & ~WR_N & wr_n_d_r;
	assign mask_go = wr_go & (REG_SELECT == SEL_MASK);
	// [RULE_22] second word decode
	assign cmd_go = wr_go & (REG_SELECT == SEL_CMD)
		& (DATA_IN[CMD_KIND_HI:CMD_KIND_LO] == KIND_SECOND);
	assign third_go = wr_go & (REG_SELECT == SEL_CMD)
		& (DATA_IN[CMD_KIND_HI:CMD_KIND_LO] == KIND_THIRD);
	assign op = DATA_IN[CMD_OP_HI:CMD_OP_LO];
	// [RULE_06] binary level field
	assign tgt = DATA_IN[CMD_LVL_HI:CMD_LVL_LO];
	assign ack_fall = ~INTERRUPT_ACKNOWLEDGE_STROBE_N & interrupt_acknowledge_strobe_n_d_r;
	assign ack_rise = INTERRUPT_ACKNOWLEDGE_STROBE_N & ~interrupt_acknowledge_strobe_n_d_r;
	// [RULE_19] last pulse depends on host width
	assign finish = ack_rise & ((ack_st_r == ACK_TWO & HOST_16BIT)
		| ack_st_r == ACK_THREE);

	// [RULE_01] requests gated until initialized
	// [RULE_03] per-channel mask
	assign req_live = INIT_DONE ? (REQ & ~mask_r) : 8'h00;
	// [RULE_20] special mask drops nesting; in-service level still not re-raised
	assign req_view = spec_mask_r ? (req_live & ~isr_r) : req_live;
	// [RULE_18] masked in-service bits are invisible in special mask
	assign isr_view = spec_mask_r ? (isr_r & ~mask_r) : isr_r;

	ipc_priority_pick #(.W(8), .LW(3)) u_pick_req
	(
		.bits(req_view),
		.lowest(lowest_r),
		.found(req_found),
		.level(req_lvl)
	);

	ipc_priority_pick #(.W(8), .LW(3)) u_pick_isr
	(
		.bits(isr_view),
		.lowest(lowest_r),
		.found(isr_found),
		.level(isr_lvl)
	);

	// [RULE_12] outside special mask, only strictly higher priority passes an in-service level
	assign req_wins = req_found & (spec_mask_r | ~isr_found
		| (rank(req_lvl, lowest_r) < rank(isr_lvl, lowest_r)));

	always_comb
	begin
		mask_nxt = mask_r;
		isr_nxt = isr_r;
		lowest_nxt = lowest_r;
		spec_mask_nxt = spec_mask_r;
		rot_nxt = rot_r;
		ack_st_nxt = ack_st_r;
		ack_lvl_nxt = ack_lvl_r;
		// [RULE_02] mask write
		if (mask_go)
			mask_nxt = DATA_IN;
		if (cmd_go)
		begin
			// [RULE_04] end of service codes
			// [RULE_05] rotation codes
			unique case (op)
				OP_NS_EOS:
					// [RULE_16] highest set bit cleared
					if (isr_found)
						isr_nxt[isr_lvl] = 1'b0;
				OP_SP_EOS:
					// [RULE_17] named bit cleared
					isr_nxt[tgt] = 1'b0;
				// [RULE_13] serviced level becomes lowest
				OP_ROT_NS_EOS:
					if (isr_found)
					begin
						isr_nxt[isr_lvl] = 1'b0;
						lowest_nxt = isr_lvl;
					end
				OP_ROT_SP_EOS:
				begin
					isr_nxt[tgt] = 1'b0;
					lowest_nxt = tgt;
				end
				OP_SET_PRI:
					lowest_nxt = tgt;
				OP_ROT_AUTO_SET:
					rot_nxt = 1'b1;
				OP_ROT_AUTO_CLR:
					rot_nxt = 1'b0;
				// [RULE_23] nothing changes
				OP_NOP:
					isr_nxt = isr_r;
			endcase
		end
		// [RULE_07] special mask only moves with its enable set
		if (third_go && DATA_IN[SPEC_MASK_EN_BIT])
			spec_mask_nxt = DATA_IN[SPEC_MASK_BIT];
		// acknowledge after the commands, so a set beats a command clear in the same cycle
		unique case (ack_st_r)
			ACK_IDLE:
			begin
				if (ack_fall)
				begin
					ack_st_nxt = ACK_ONE;
					// a request gone by now yields the default level unset
					ack_lvl_nxt = req_wins ? req_lvl : DEFAULT_LVL;
					// [RULE_10] winner goes in service
					if (req_wins)
						isr_nxt[req_lvl] = 1'b1;
				end
			end
			ACK_ONE:
				if (ack_fall)
					ack_st_nxt = ACK_TWO;
			ACK_TWO:
				if (finish)
					ack_st_nxt = ACK_IDLE;
				else if (ack_fall)
					ack_st_nxt = ACK_THREE;
			ACK_THREE:
				if (finish)
					ack_st_nxt = ACK_IDLE;
		endcase
		// [RULE_11] automatic clear at the final rising edge
		if (finish && AUTO_EOS && isr_found)
		begin
			isr_nxt[isr_lvl] = 1'b0;
			if (rot_r)
				lowest_nxt = isr_lvl;
		end
		// [RULE_08] defaults hold until initialized
		// [RULE_09] channel 0 highest
		if (!INIT_DONE)
		begin
			isr_nxt = ISR_RST;
			lowest_nxt = LOWEST_RST;
			spec_mask_nxt = 1'b0;
			rot_nxt = 1'b0;
			ack_st_nxt = ACK_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			wr_n_d_r <= 1'b1;
			interrupt_acknowledge_strobe_n_d_r <= 1'b1;
			mask_r <= MASK_RST;
			isr_r <= ISR_RST;
			lowest_r <= LOWEST_RST;
			spec_mask_r <= 1'b0;
			rot_r <= 1'b0;
			ack_st_r <= ACK_IDLE;
			ack_lvl_r <= DEFAULT_LVL;
		end
		else
		begin
			wr_n_d_r <= WR_N;
			interrupt_acknowledge_strobe_n_d_r <= INTERRUPT_ACKNOWLEDGE_STROBE_N;
			mask_r <= mask_nxt;
			isr_r <= isr_nxt;
			lowest_r <= lowest_nxt;
			spec_mask_r <= spec_mask_nxt;
			rot_r <= rot_nxt;
			ack_st_r <= ack_st_nxt;
			ack_lvl_r <= ack_lvl_nxt;
		end
	end

	// vector is driven while the final pulse is low
	assign ack_vec = ~INTERRUPT_ACKNOWLEDGE_STROBE_N & ((ack_st_r == ACK_TWO & HOST_16BIT)
		| ack_st_r == ACK_THREE);
	// [RULE_21] mask read needs no prior select command
	assign rd_mask = ~SEL_N & ~RD_N & (REG_SELECT == SEL_MASK);

	always_comb
	begin
		int_nxt = req_wins & (ack_st_r == ACK_IDLE);
		if (ack_vec)
			dout_nxt = {VECTOR_BASE[7:VEC_BASE_LO], ack_lvl_r};
		else if (rd_mask)
			dout_nxt = mask_r;
		else
			dout_nxt = 8'h00;
		oe_n_nxt = ~(ack_vec | (~SEL_N & ~RD_N));
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			int_r <= 1'b0;
			dout_r <= 8'h00;
			oe_n_r <= 1'b1;
		end
		else
		begin
			int_r <= int_nxt;
			dout_r <= dout_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign INT_OUT = int_r;
	assign DATA_OUT = dout_r;
	assign DATA_OE_N = oe_n_r;
	assign IN_SERVICE = isr_r;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	chk_init_hold: assert property ( // [RULE_01]
		!INIT_DONE |=> !INT_OUT && IN_SERVICE == 8'h00)
		else $error("activity before initialization");
	chk_mask_write: assert property ( // [RULE_02]
		mask_go |=> mask_r == $past(DATA_IN))
		else $error("mask write lost");
	chk_masked_quiet: assert property ( // [RULE_03]
		(REQ & ~mask_r) == 8'h00 |=> !INT_OUT)
		else $error("masked channel raised interrupt");
	chk_spec_mask_set: assert property ( // [RULE_07]
		third_go && INIT_DONE |=> spec_mask_r ==
		($past(DATA_IN[SPEC_MASK_EN_BIT]) ? $past(DATA_IN[SPEC_MASK_BIT])
		: $past(spec_mask_r)))
		else $error("special mask mode wrong");
	chk_ack_sets: assert property ( // [RULE_10]
		ack_fall && ack_st_r == ACK_IDLE && req_wins && INIT_DONE
		|=> isr_r[$past(req_lvl)] ##0 ack_st_r == ACK_ONE)
		else $error("acknowledge did not set in-service");
	chk_auto_clear: assert property ( // [RULE_11]
		finish && AUTO_EOS && isr_found && INIT_DONE
		|=> !isr_r[$past(isr_lvl)] ##0 ack_st_r == ACK_IDLE)
		else $error("automatic clear missed");
	chk_nested_block: assert property ( // [RULE_12]
		!spec_mask_r && isr_found && req_found
		&& rank(req_lvl, lowest_r) >= rank(isr_lvl, lowest_r) |=> !INT_OUT)
		else $error("lower priority passed in-service level");
	chk_set_priority: assert property ( // [RULE_13]
		cmd_go && op == OP_SET_PRI && INIT_DONE && !finish
		|=> lowest_r == $past(tgt))
		else $error("priority not set");
	chk_ns_clear: assert property ( // [RULE_16]
		cmd_go && op == OP_NS_EOS && isr_found && !ack_fall && INIT_DONE
		|=> !isr_r[$past(isr_lvl)])
		else $error("non-specific clear missed");
	chk_sp_clear: assert property ( // [RULE_17]
		cmd_go && op == OP_SP_EOS && !ack_fall && INIT_DONE
		|=> !isr_r[$past(tgt)])
		else $error("specific clear missed");
	chk_nop_still: assert property ( // [RULE_23]
		cmd_go && op == OP_NOP && !ack_fall && !finish && INIT_DONE
		|=> $stable(isr_r) && $stable(lowest_r) && $stable(rot_r))
		else $error("no-operation changed state");
	chk_mask_read: assert property ( // [RULE_21]
		rd_mask && !ack_vec |=> DATA_OUT == $past(mask_r) && !DATA_OE_N)
		else $error("mask read wrong");

	cov_ack_third: cover property (ack_st_r == ACK_THREE && finish);
	cov_ack_second: cover property (ack_st_r == ACK_TWO && finish);
	cov_rotate: cover property (cmd_go && op == OP_ROT_NS_EOS && isr_found);
	cov_spec_mask_int: cover property (spec_mask_r && INT_OUT
		&& isr_r != 8'h00);
endmodule

// File: verilog/ipc_priority_pick.sv
// rotating priority picker: highest-priority set bit under a lowest level
`timescale 1ns/10ps
module ipc_priority_pick
#(
	parameter int W = 8,
	parameter int LW = 3
)
(
	input wire logic [W-1:0] bits,
	input wire logic [LW-1:0] lowest,
	output logic found,
	output logic [LW-1:0] level
);
	if (W != (1 << LW))
	begin : g_bad_width
		$error("picker width must be two to the level width");
	end

	logic [LW-1:0] idx;

	// scan from lowest up to highest so the highest priority is written last
	always_comb
	begin
		idx = '0;
		found = 1'b0;
		level = '0;
		for (int k = W; k >= 1; k--)
		begin
			idx = LW'(lowest + LW'(k));
			if (bits[idx])
			begin
				found = 1'b1;
				level = idx;
			end
		end
	end
endmodule
